// ---- rtl/cscl_counter_latch.sv ----
// cell statistics counter latch: accumulators, holding registers, status, interrupt
// assumes a classic wishbone master on clk_i and event pulses synchronous to clk_i
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

module cscl_counter_latch
  import cscl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // cell pipeline events and congestion-driven discard
  input wire cscl_pkg::cscl_event_t events_i,
  input wire logic backpressure_discard_in_i,
  // interrupt
  output logic irq_o
);
  import cscl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // event classification
  // software must trigger often enough that sixteen bits do not roll over;
  // the bank gives no warning when an accumulator wraps, it just restarts

  logic count_undefined_type_as_valid;
  logic count_pti_as_invalid;
  logic [3:0] inc;

  // events arrive from same-clock logic, so no synchroniser here; a
  // synchroniser would also skew an event against the congestion level
  // that qualifies it, and the discard count would then drift
  // each cell raises at most one crc flag; the type flag only qualifies a
  // good-crc maintenance cell, so a bad-crc cell is never counted twice
  always_comb
  begin
    inc[0] = events_i.maint_crc_ok &
      (!events_i.maint_type_undef | count_undefined_type_as_valid);
    inc[1] = events_i.maint_crc_bad |
      (events_i.maint_crc_ok & events_i.maint_type_undef &
       !count_undefined_type_as_valid);
    inc[2] = events_i.hdr_unprov | (events_i.hdr_pti_undef & count_pti_as_invalid);
    inc[3] = events_i.cell_discard & backpressure_discard_in_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus decode

  cscl_bus_state_t bus_state;
  cscl_bus_state_t next_bus_state;
  logic req;
  logic wr;
  logic rd;
  logic trigger;
  logic status_read;

  // a request is taken only while idle; in the ack cycle the master still
  // holds cyc and stb, and taking it again would answer one access twice
  assign req = wb_cyc_i & wb_stb_i & (bus_state == CSCL_IDLE);
  assign wr = req & wb_we_i;
  assign rd = req & !wb_we_i;
  // only the address matters, the data is dropped; sel is ignored too so a
  // byte-wide master can still fire a transfer with any lane enabled
  // writes to the read-only count locations land here and nowhere else
  assign trigger = wr & ((wb_adr_i == CSCL_IDX_TRIGGER) |
    ((wb_adr_i >= CSCL_IDX_VALID) & (wb_adr_i <= CSCL_IDX_DISCARD)));
  assign status_read = rd & (wb_adr_i == CSCL_IDX_STATUS);

  // one ack per request, then a forced idle cycle so a held stb is not taken twice
  // the cost is one dead cycle between back-to-back accesses, which a
  // statistics bank read now and then can well afford
  always_comb
  begin
    case (bus_state)
      CSCL_IDLE: next_bus_state = req ? CSCL_ACK : CSCL_IDLE;
      CSCL_ACK: next_bus_state = CSCL_IDLE;
      default: next_bus_state = CSCL_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // accumulators and holding registers

  // one accumulator and one holding register per count kind
  localparam int CSCL_N_CNT = 4;

  logic [CSCL_CNT_W-1:0] acc [CSCL_N_CNT];
  logic [CSCL_CNT_W-1:0] next_acc [CSCL_N_CNT];
  logic [CSCL_CNT_W-1:0] held [CSCL_N_CNT];
  logic [CSCL_CNT_W-1:0] next_held [CSCL_N_CNT];

  // transfer happens at the edge that takes the write: one cycle, inside three
  // snapshot and restart share one edge, so there is no window in which an
  // event could fall between the copy and the clear; an event in that very
  // cycle is the first of the new accumulation rather than the last of the old
  // a full accumulator rolls over silently; software that triggers less often
  // than the fastest event rate allows will see a short count
  genvar g;
  generate
    for (g = 0; g < CSCL_N_CNT; g++)
    begin : g_cnt
      always_comb
      begin
        next_held[g] = held[g];
        next_acc[g] = acc[g] + (inc[g] ? CSCL_CNT_ONE : CSCL_CNT_ZERO);
        if (trigger)
        begin
          next_held[g] = acc[g];
          // event in the latch cycle starts the new accumulation
          next_acc[g] = inc[g] ? CSCL_CNT_ONE : CSCL_CNT_ZERO;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // status, config and interrupt

  logic transfer_done;
  logic holding_overrun;
  logic next_transfer_done;
  logic next_holding_overrun;
  logic [1:0] cfg;
  logic [1:0] next_cfg;
  logic counter_transfer_irq_flag;
  logic next_irq_flag;
  logic irq_mask;
  logic next_irq_mask;
  logic [5:0] status_word;

  assign count_undefined_type_as_valid = cfg[CSCL_CFG_UNDEF_VALID];
  assign count_pti_as_invalid = cfg[CSCL_CFG_PTI_INVALID];

  // non-zero flags follow the held values, so they describe the snapshot
  // software is about to read, not the counts still climbing behind it

  always_comb
  begin
    status_word = '0;
    status_word[CSCL_ST_OVERRUN] = holding_overrun;
    status_word[CSCL_ST_TRANSFER_DONE] = transfer_done;
    status_word[CSCL_ST_VALID_NZ] = held[0] != CSCL_CNT_ZERO;
    status_word[CSCL_ST_ERR_NZ] = held[1] != CSCL_CNT_ZERO;
    status_word[CSCL_ST_BAD_NZ] = held[2] != CSCL_CNT_ZERO;
    status_word[CSCL_ST_DISC_NZ] = held[3] != CSCL_CNT_ZERO;
  end

  // a trigger and a status read cannot share a cycle (one request per access),
  // yet set is still written last so it would win
  always_comb
  begin
    next_transfer_done = transfer_done;
    next_holding_overrun = holding_overrun;
    next_irq_flag = counter_transfer_irq_flag;
    next_cfg = cfg;
    next_irq_mask = irq_mask;
    if (status_read)
    begin
      next_transfer_done = 1'b0;
      next_holding_overrun = 1'b0;
    end
    // config, mask and interrupt clear are narrow fields in byte lane 0,
    // so only that lane's enable gates them
    if (wr && wb_adr_i == CSCL_IDX_CONFIG && wb_sel_i[0])
      next_cfg = wb_dat_i[1:0];
    if (wr && wb_adr_i == CSCL_IDX_IRQ_MASK && wb_sel_i[0])
      next_irq_mask = wb_dat_i[CSCL_IRQ_TRANSFER_DONE];
    if (wr && wb_adr_i == CSCL_IDX_IRQ_STATUS && wb_sel_i[0] && wb_dat_i[CSCL_IRQ_TRANSFER_DONE])
      next_irq_flag = 1'b0;
    if (trigger)
    begin
      next_transfer_done = 1'b1;
      next_irq_flag = 1'b1;
      // a second transfer before software acknowledged the first: the old
      // snapshot is gone, so flag it for software to discard its view
      if (transfer_done)
        next_holding_overrun = 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read data

  // read map: status at 0x30, the four held counts at 0x31..0x34, config at
  // 0x40, interrupt flag at 0x41 and its mask at 0x42; the trigger index and
  // every unmapped index read as zero, and unused upper bits are always zero
  // reading a count does not disturb it; only the status read has a side effect
  logic [31:0] next_dat;

  always_comb
  begin
    next_dat = '0;
    if (rd)
    begin
      case (wb_adr_i)
        CSCL_IDX_STATUS: next_dat[5:0] = status_word;
        CSCL_IDX_VALID: next_dat[15:0] = held[0];
        CSCL_IDX_ERRORED: next_dat[15:0] = held[1];
        CSCL_IDX_BADHDR: next_dat[15:0] = held[2];
        CSCL_IDX_DISCARD: next_dat[15:0] = held[3];
        CSCL_IDX_CONFIG: next_dat[1:0] = cfg;
        CSCL_IDX_IRQ_STATUS: next_dat[CSCL_IRQ_TRANSFER_DONE] = counter_transfer_irq_flag;
        CSCL_IDX_IRQ_MASK: next_dat[CSCL_IRQ_TRANSFER_DONE] = irq_mask;
        default: next_dat = '0;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers
  // every group of state is registered on its own; all share the one
  // synchronous reset, so the whole bank leaves reset on the same edge

  // bus handshake: the ack flop is the only timing the master relies on
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      bus_state <= CSCL_IDLE;
      wb_ack_o <= 1'b0;
    end
    else
    begin
      bus_state <= next_bus_state;
      wb_ack_o <= req;
    end
  end

  // read data comes straight from a flop and is zero outside the ack cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= '0;
    end
    else
    begin
      wb_dat_o <= next_dat;
    end
  end

  // accumulators and holding registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < CSCL_N_CNT; i++)
      begin
        acc[i] <= CSCL_CNT_ZERO;
        held[i] <= CSCL_CNT_ZERO;
      end
    end
    else
    begin
      for (int i = 0; i < CSCL_N_CNT; i++)
      begin
        acc[i] <= next_acc[i];
        held[i] <= next_held[i];
      end
    end
  end

  // transfer status flags
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      transfer_done <= 1'b0;
      holding_overrun <= 1'b0;
    end
    else
    begin
      transfer_done <= next_transfer_done;
      holding_overrun <= next_holding_overrun;
    end
  end

  // configuration
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg <= CSCL_CFG_RESET;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // interrupt flag, mask and output; the output uses the next values so it
  // rises on the same edge as the flag instead of one cycle behind it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      counter_transfer_irq_flag <= 1'b0;
      irq_mask <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      counter_transfer_irq_flag <= next_irq_flag;
      irq_mask <= next_irq_mask;
      irq_o <= next_irq_flag & next_irq_mask;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/cscl_pkg.sv ----
// package for the cell statistics counter latch block
// shared by the register bank and the verification side
package cscl_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] CSCL_IDX_TRIGGER = 8'h00;
  localparam logic [7:0] CSCL_IDX_STATUS = 8'h30;
  localparam logic [7:0] CSCL_IDX_VALID = 8'h31;
  localparam logic [7:0] CSCL_IDX_ERRORED = 8'h32;
  localparam logic [7:0] CSCL_IDX_BADHDR = 8'h33;
  localparam logic [7:0] CSCL_IDX_DISCARD = 8'h34;
  localparam logic [7:0] CSCL_IDX_CONFIG = 8'h40;
  localparam logic [7:0] CSCL_IDX_IRQ_STATUS = 8'h41;
  localparam logic [7:0] CSCL_IDX_IRQ_MASK = 8'h42;

  // status register bit positions
  localparam int CSCL_ST_OVERRUN = 0;
  localparam int CSCL_ST_TRANSFER_DONE = 1;
  localparam int CSCL_ST_VALID_NZ = 2;
  localparam int CSCL_ST_ERR_NZ = 3;
  localparam int CSCL_ST_BAD_NZ = 4;
  localparam int CSCL_ST_DISC_NZ = 5;

  // configuration bit positions
  localparam int CSCL_CFG_UNDEF_VALID = 0;
  localparam int CSCL_CFG_PTI_INVALID = 1;
  localparam logic [1:0] CSCL_CFG_RESET = 2'h0;

  // interrupt bit positions
  localparam int CSCL_IRQ_TRANSFER_DONE = 0;

  localparam int CSCL_CNT_W = 16;
  localparam logic [15:0] CSCL_CNT_ZERO = 16'h0000;
  localparam logic [15:0] CSCL_CNT_ONE = 16'h0001;

  // events from the cell pipeline, one-cycle pulses
  typedef struct packed {
    logic maint_crc_ok;
    logic maint_crc_bad;
    logic maint_type_undef;
    logic hdr_unprov;
    logic hdr_pti_undef;
    logic cell_discard;
  } cscl_event_t;

  typedef enum logic [1:0] {
    CSCL_IDLE,
    CSCL_ACK
  } cscl_bus_state_t;

endpackage

// ---- tb/cscl_checker.sv ----
// concurrent checks for the counter latch bank
// sees only the top ports; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module cscl_checker
  import cscl_pkg::*;
(
  // clock, reset and bus
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // interrupt
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic trg;
  logic rd_st;
  logic [1:0] ntr;
  logic [1:0] next_ntr;
  // address is still held in the ack cycle, so decode there
  assign trg = wb_ack_o && wb_we_i && (wb_adr_i == CSCL_IDX_TRIGGER
    || (wb_adr_i >= CSCL_IDX_VALID && wb_adr_i <= CSCL_IDX_DISCARD));
  assign rd_st = wb_ack_o && !wb_we_i && wb_adr_i == CSCL_IDX_STATUS;
  // transfers since the last status read, saturating at two
  always_comb next_ntr = rd_st ? 2'h0 : (trg && ntr != 2'h2) ? ntr + 2'h1 : ntr;
  always_ff @(posedge clk_i) ntr <= rst_i ? 2'h0 : next_ntr;
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_pulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_pulse: assert property (s_take |=> s_pulse)
    else $error("bus ack not a one-cycle answer");
  a_idle_data: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_count_width: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
    else $error("upper read bits set");
  a_transfer_done_seen: assert property (rd_st && ntr != 2'h0 |-> wb_dat_o[CSCL_ST_TRANSFER_DONE])
    else $error("transfer done missing");
  a_read_clears: assert property (rd_st && ntr == 2'h0 |-> wb_dat_o[1:0] == 2'h0)
    else $error("flags survive status read");
  a_overrun_set: assert property (rd_st |-> wb_dat_o[0] == (ntr == 2'h2))
    else $error("overrun flag wrong");
  a_status_top: assert property (rd_st |-> wb_dat_o[15:6] == 10'h0)
    else $error("status unused bits set");
  a_irq_cause: assert property ($changed(irq_o) |-> wb_ack_o || $past(wb_ack_o))
    else $error("irq moved without bus access");
endmodule
bind cscl_counter_latch cscl_checker u_cscl_checker (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o));
`default_nettype wire

// ---- tb/cscl_counter_latch_bench.sv ----
// bench for the counter latch: random events, bus traffic, wrap, interrupt
// drives every port itself; a model mirrors the counts at each edge
`timescale 1ns/1ps
`default_nettype none
module cscl_counter_latch_bench;
  import cscl_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic [31:0] q;
  logic [31:0] e;
  logic wb_ack_o, irq_o, tk;
  logic bp = 1'b0;
  logic wrap = 1'b0;
  logic xf, ov;
  logic [1:0] cfg;
  logic [3:0] inc;
  logic [15:0] acc [4];
  logic [15:0] held [4];
  cscl_event_t ev = '0;
  logic [7:0] trig [5] = '{8'h00, 8'h31, 8'h32, 8'h33, 8'h34};
  int n_mismatch = 0;
  int n_compared = 0;
  int r;
  always #5 clk_i = ~clk_i;
  cscl_counter_latch u_cscl_counter_latch (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .events_i(ev), .backpressure_discard_in_i(bp), .irq_o(irq_o));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic is_trig(input logic [7:0] a);
    return a == CSCL_IDX_TRIGGER || (a >= CSCL_IDX_VALID && a <= CSCL_IDX_DISCARD);
  endfunction
  function automatic logic [31:0] exp_status();
    return {26'h0, held[3] != 0, held[2] != 0, held[1] != 0, held[0] != 0, xf, ov};
  endfunction
  // model: classify events, latch on trigger take; a coincident event starts the new count
  always @(posedge clk_i)
  begin
    tk = wb_cyc_i && wb_stb_i && !wb_ack_o;
    inc = {ev.cell_discard && bp, ev.hdr_unprov || (ev.hdr_pti_undef && cfg[1]),
      ev.maint_crc_bad || (ev.maint_crc_ok && ev.maint_type_undef && !cfg[0]),
      ev.maint_crc_ok && (!ev.maint_type_undef || cfg[0])};
    if (rst_i)
    begin
      acc = '{4{16'h0}};
      held = '{4{16'h0}};
      cfg = 2'h0;
      {xf, ov} = 2'h0;
    end
    else if (tk && wb_we_i && is_trig(wb_adr_i))
    begin
      ov = ov | xf;
      xf = 1'b1;
      held = acc;
      for (int i = 0; i < 4; i++) acc[i] = {15'h0, inc[i]};
    end
    else
    begin
      for (int i = 0; i < 4; i++) acc[i] = acc[i] + {15'h0, inc[i]};
      if (tk && wb_we_i && wb_adr_i == CSCL_IDX_CONFIG && wb_sel_i[0]) cfg = wb_dat_i[1:0];
      if (tk && !wb_we_i && wb_adr_i == CSCL_IDX_STATUS) {xf, ov} = 2'h0;
    end
    // both crc flags never high together
    r = $urandom;
    ev <= wrap ? cscl_event_t'(6'h01) : cscl_event_t'({r[5], r[4] & ~r[5], r[3:0]});
    bp <= wrap | r[6];
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    n_compared++;
    if (s !== x)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, x, s);
    end
  endtask
  // one classic cycle, then one idle cycle
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_mismatch++;
      finish_test();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    r = $urandom(32'h4adc5e16);
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    bus(1'b1, CSCL_IDX_STATUS, 32'hFFFF);
    for (int a = 8'h30; a < 8'h35; a++)
    begin
      bus(1'b0, 8'(a), 32'h0);
      chk("reset value", 32'h0, q);
    end
    bus(1'b0, 8'h7F, 32'h0);
    chk("unmapped", 32'h0, q);
    // every config value and trigger address; odd passes overrun
    for (int k = 0; k < 5; k++)
    begin
      bus(1'b1, CSCL_IDX_CONFIG, 32'(k % 4));
      repeat (150 + $urandom % 100) @(posedge clk_i);
      bus(1'b1, trig[k], $urandom);
      if (k % 2 == 1) bus(1'b1, trig[4 - k], $urandom);
      for (int a = 0; a < 4; a++)
      begin
        bus(1'b0, CSCL_IDX_VALID + 8'(a), 32'h0);
        chk("held count", {16'h0, held[a]}, q);
      end
      e = exp_status();
      bus(1'b0, CSCL_IDX_STATUS, 32'h0);
      chk("status", e, q);
    end
    // interrupt cleared, raised, masked
    bus(1'b1, CSCL_IDX_IRQ_MASK, 32'h1);
    bus(1'b1, CSCL_IDX_IRQ_STATUS, 32'h1);
    chk("irq cleared", 32'h0, {31'h0, irq_o});
    bus(1'b1, trig[0], 32'h0);
    chk("irq raised", 32'h1, {31'h0, irq_o});
    bus(1'b1, CSCL_IDX_IRQ_MASK, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq_o});
    bus(1'b0, CSCL_IDX_IRQ_STATUS, 32'h0);
    chk("irq flag", 32'h1, q);
    // discard on every cycle, past the 16-bit range
    wrap <= 1'b1;
    repeat (65540) @(posedge clk_i);
    wrap <= 1'b0;
    bus(1'b1, trig[1], 32'h0);
    bus(1'b0, CSCL_IDX_DISCARD, 32'h0);
    chk("discard wrap", {16'h0, held[3]}, q);
    finish_test();
  end
endmodule
`default_nettype wire
